// ### rtl/cdt_pkg.sv
// constants and types for the contact delay timer
package cdt_pkg;
    // ----------------------------------------
    // register map (word-aligned byte addresses)
    // ----------------------------------------
    localparam logic [7:0] CDT_ADDR_ON_DELAY = 8'h00;
    localparam logic [7:0] CDT_ADDR_OFF_DELAY = 8'h04;
    localparam logic [7:0] CDT_ADDR_IN_SEL = 8'h08;
    localparam logic [7:0] CDT_ADDR_OUT_SEL = 8'h0c;
    localparam logic [7:0] CDT_ADDR_STATUS = 8'h10;
    // ----------------------------------------
    // fields and values
    // ----------------------------------------
    localparam int CDT_DLY_W = 15;
    localparam int CDT_SEL_W = 8;
    localparam logic [CDT_DLY_W-1:0] CDT_DLY_MAX = 15'h7530;
    localparam logic [CDT_DLY_W-1:0] CDT_DLY_RST = 15'h0000;
    localparam logic [CDT_SEL_W-1:0] CDT_SEL_RST = 8'h00;
    localparam logic [CDT_SEL_W-1:0] CDT_IN_TIMER = 8'h12;
    localparam logic [CDT_SEL_W-1:0] CDT_OUT_TIMER = 8'h0c;
    localparam int CDT_ST_OUT = 0;
    localparam int CDT_ST_EN = 1;
    localparam int CDT_ST_IN = 2;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CDT_CLK_HZ = 200000000;
    localparam real CDT_TICK_S = 0.1;
    localparam int CDT_TICK_CYC = int'(CDT_TICK_S * CDT_CLK_HZ);
    localparam int CDT_TICK_W = 25;
    typedef enum logic [1:0] {
        CDT_OFF = 2'b00,
        CDT_ARM_ON = 2'b01,
        CDT_ON = 2'b11,
        CDT_ARM_OFF = 2'b10
    } cdt_state_e;
endpackage : cdt_pkg

// ### rtl/cdt_tick.sv
// time-base divider: one-cycle enable every tick period
`timescale 1ns/1ps
module cdt_tick import cdt_pkg::*; #(
    parameter int TICK_CYC = CDT_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    typedef struct packed {
        logic [CDT_TICK_W-1:0] cnt;
        logic tick;
    } cdt_tick_s;
    cdt_tick_s st_q, st_d;
    localparam logic [CDT_TICK_W-1:0] LAST = CDT_TICK_W'(TICK_CYC - 1);
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == LAST) begin
            st_d.cnt = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign tick = st_q.tick;
endmodule : cdt_tick

// ### rtl/cdt_timer.sv
// contact delay timer with register port
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module cdt_timer import cdt_pkg::*; #(
    parameter int TICK_CYC = CDT_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic timer_in,
    output logic timer_out
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [CDT_DLY_W-1:0] on_delay_setting;
        logic [CDT_DLY_W-1:0] off_delay_setting;
        logic [CDT_SEL_W-1:0] input_function_select;
        logic [CDT_SEL_W-1:0] output_function_select;
        logic [2:0] sync;
        logic in_lvl;
        cdt_state_e fsm;
        logic [CDT_DLY_W-1:0] cnt;
        logic out;
        logic [31:0] rdata;
    } cdt_s;
    cdt_s st_q, st_d;
    logic tick;
    logic en;
    logic in_new;

    // reset image: settings back at their zero defaults, timer idle, output off
    localparam cdt_s ST_RST = '{
        on_delay_setting: CDT_DLY_RST,
        off_delay_setting: CDT_DLY_RST,
        input_function_select: CDT_SEL_RST,
        output_function_select: CDT_SEL_RST,
        sync: '0,
        in_lvl: 1'b0,
        fsm: CDT_OFF,
        cnt: '0,
        out: 1'b0,
        rdata: '0
    };

    // ----------------------------------------
    // time base
    // ----------------------------------------
    // single divider serves the single timer
    cdt_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(tick)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // clamps writes above the documented range
    function automatic logic [CDT_DLY_W-1:0] clamp_dly(input logic [31:0] v);
        clamp_dly = (v > 32'(CDT_DLY_MAX)) ? CDT_DLY_MAX : v[CDT_DLY_W-1:0];
    endfunction : clamp_dly

    // a zero setting switches at once; any other needs one tick beyond its value,
    // since the free-running tick may fall a single cycle after arming
    function automatic logic dly_done(
        input logic [CDT_DLY_W-1:0] cnt,
        input logic [CDT_DLY_W-1:0] setting
    );
        if (setting == '0) begin
            dly_done = 1'b1;
        end else begin
            dly_done = (cnt > setting);
        end
    endfunction : dly_done

    // counts only on the time-base enable; holds at full scale rather than wrap
    function automatic logic [CDT_DLY_W-1:0] dly_step(
        input logic [CDT_DLY_W-1:0] cnt,
        input logic tick_en
    );
        if (tick_en && (cnt != '1)) begin
            dly_step = cnt + 1'b1;
        end else begin
            dly_step = cnt;
        end
    endfunction : dly_step

    // a new level counts only when the second and third stages agree
    function automatic logic filt_level(
        input logic [2:0] sync,
        input logic prev
    );
        if (sync[2] == sync[1]) begin
            filt_level = sync[2];
        end else begin
            filt_level = prev;
        end
    endfunction : filt_level

    // one read mux for every address; unmapped reads return zero
    function automatic logic [31:0] reg_read(
        input logic [7:0] a,
        input cdt_s s,
        input logic enabled
    );
        reg_read = '0;
        unique case (a)
            CDT_ADDR_ON_DELAY: reg_read = 32'(s.on_delay_setting);
            CDT_ADDR_OFF_DELAY: reg_read = 32'(s.off_delay_setting);
            CDT_ADDR_IN_SEL: reg_read = 32'(s.input_function_select);
            CDT_ADDR_OUT_SEL: reg_read = 32'(s.output_function_select);
            CDT_ADDR_STATUS: begin
                reg_read[CDT_ST_OUT] = s.out;
                reg_read[CDT_ST_EN] = enabled;
                reg_read[CDT_ST_IN] = s.in_lvl;
            end
            default: reg_read = '0;
        endcase
    endfunction : reg_read

    // ----------------------------------------
    // enable
    // ----------------------------------------
    assign en = (st_q.input_function_select == CDT_IN_TIMER)
        && (st_q.output_function_select == CDT_OUT_TIMER);

    // ----------------------------------------
    // logic
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.rdata = '0;
        // ----------------------------------------
        // input filter
        // ----------------------------------------
        // three-stage sync; change accepted when stages 2 and 3 agree
        st_d.sync = {st_q.sync[1:0], timer_in};
        in_new = filt_level(st_q.sync, st_q.in_lvl);
        st_d.in_lvl = in_new;
        // ----------------------------------------
        // register port
        // ----------------------------------------
        if (wr) begin
            unique case (addr)
                CDT_ADDR_ON_DELAY: st_d.on_delay_setting = clamp_dly(wdata);
                CDT_ADDR_OFF_DELAY: st_d.off_delay_setting = clamp_dly(wdata);
                CDT_ADDR_IN_SEL: st_d.input_function_select = wdata[CDT_SEL_W-1:0];
                CDT_ADDR_OUT_SEL: st_d.output_function_select = wdata[CDT_SEL_W-1:0];
                default: ;
            endcase
        end
        // read data stand for the one cycle after the strobe, zero otherwise
        if (rd) begin
            st_d.rdata = reg_read(addr, st_q, en);
        end
        // ----------------------------------------
        // delay state machine
        // ----------------------------------------
        // no drive-run input exists: timing never waits on motor state
        if (!en) begin
            st_d.fsm = CDT_OFF;
            st_d.out = 1'b0;
            st_d.cnt = '0;
        end else begin
            unique case (st_q.fsm)
                CDT_OFF: begin
                    if (in_new) begin
                        st_d.fsm = CDT_ARM_ON;
                        st_d.cnt = '0;
                    end
                end
                CDT_ARM_ON: begin
                    if (!in_new) begin
                        st_d.fsm = CDT_OFF;
                    end else if (dly_done(st_q.cnt, st_q.on_delay_setting)) begin
                        st_d.fsm = CDT_ON;
                        st_d.out = 1'b1;
                    end else begin
                        st_d.cnt = dly_step(st_q.cnt, tick);
                    end
                end
                CDT_ON: begin
                    if (!in_new) begin
                        st_d.fsm = CDT_ARM_OFF;
                        st_d.cnt = '0;
                    end
                end
                CDT_ARM_OFF: begin
                    if (in_new) begin
                        st_d.fsm = CDT_ON;
                    end else if (dly_done(st_q.cnt, st_q.off_delay_setting)) begin
                        st_d.fsm = CDT_OFF;
                        st_d.out = 1'b0;
                    end else begin
                        st_d.cnt = dly_step(st_q.cnt, tick);
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata = st_q.rdata;
    assign timer_out = st_q.out;
endmodule : cdt_timer

// ### verification/cdt_contact_model.sv
// contact that the timer watches, moved on the bench's command
`timescale 1ns/1ps
module cdt_contact_model (
    input wire logic clk,
    input wire logic closed,
    output logic contact
);
    // one cycle of travel, so the pin never moves in step with the bench
    initial contact = 1'b0;
    always @(posedge clk) begin
        contact <= closed;
    end
endmodule : cdt_contact_model

// ### verification/cdt_timer_props.sv
// port assertions for the contact delay timer
`timescale 1ns/1ps
module cdt_timer_props import cdt_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic timer_in,
    input wire logic timer_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_stat_rd;
        rd && addr == CDT_ADDR_STATUS ##1 1'b1;
    endsequence
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0) else $error("stray rdata");
    a_rdata_top: assert property (rdata[31:15] == 17'h0) else $error("rdata top set");
    a_reset_quiet: assert property ($past(rst) |-> !timer_out) else $error("out after reset");
    a_on_cause: assert property ($rose(timer_out) |-> $past(timer_in, 2) || $past(timer_in, 3))
        else $error("on without input");
    a_off_cause: assert property ($fell(timer_out) |-> !$past(timer_in, 2) ||
        !$past(timer_in, 3) || $past(wr, 1) || $past(wr, 2)) else $error("off w/o input");
    a_stat_out: assert property (s_stat_rd |-> rdata[CDT_ST_OUT] == $past(timer_out))
        else $error("status out bit");
    a_stat_gate: assert property (s_stat_rd |-> rdata[CDT_ST_EN] || !rdata[CDT_ST_OUT])
        else $error("out while disabled");
    a_sel_width: assert property (rd && addr == CDT_ADDR_IN_SEL |=> rdata[31:8] == 24'h0)
        else $error("selector width");
endmodule : cdt_timer_props
bind cdt_timer cdt_timer_props u_props (.clk(clk), .rst(rst), .addr(addr), .wr(wr), .rd(rd),
    .rdata(rdata), .timer_in(timer_in), .timer_out(timer_out));

// ### verification/tb_top.sv
// self-checking bench for the contact delay timer
`timescale 1ns/1ps
module tb_top import cdt_pkg::*;;
    // short tick keeps the run small; bounds below scale with it
    localparam int TK = 10;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, cmd = 1'b0, tin, tout;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    int mismatches = 0, comparisons = 0, n, s, on_d, off_d;
    always #2.5 clk = ~clk;
    cdt_contact_model u_cm (.clk(clk), .closed(cmd), .contact(tin));
    cdt_timer #(.TICK_CYC(TK)) uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .timer_in(tin), .timer_out(tout));
    task automatic stop_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // the contact must stand past the whole setting at the pin; one tick of
    // resolution plus pin, filter and state pipeline bounds the wait from above
    function automatic int min_cyc(input int d);
        return d * TK + 1;
    endfunction : min_cyc
    function automatic int max_cyc(input int d);
        return (d == 0) ? 8 : (d + 1) * TK + 8;
    endfunction : max_cyc
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_chk
    task automatic wait_out(input logic v);
        n = 0;
        #1;
        while (tout !== v && n < 1000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 1000) begin
            mismatches++;
            stop_test();
        end
    endtask : wait_out
    // move the contact and time the output against the programmed delay
    task automatic delay_run(input logic v, input int d);
        @(posedge clk);
        cmd <= v;
        wait_out(v);
        chk({31'h0, n > min_cyc(d)}, 32'h1);
        chk({31'h0, n <= max_cyc(d)}, 32'h1);
    endtask : delay_run
    // bounce shorter than the programmed delay under test must never reach the output
    task automatic chatter(input logic v, input int d);
        s = $urandom_range(1, (d - 1) * TK - 4);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            cmd <= (i < s) ? ~v : v;
            #1 chk({31'h0, tout}, {31'h0, v});
        end
    endtask : chatter
    initial begin
        void'($urandom(32'hf1da));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 6; a++) rd_chk(8'(a * 4), 32'h0);
        wr_reg(CDT_ADDR_ON_DELAY, 32'hffff);
        rd_chk(CDT_ADDR_ON_DELAY, {17'h0, CDT_DLY_MAX});
        wr_reg(CDT_ADDR_ON_DELAY, 32'h0);
        wr_reg(CDT_ADDR_IN_SEL, {24'h0, CDT_IN_TIMER});
        wr_reg(CDT_ADDR_OUT_SEL, $urandom_range(0, 11));
        cmd <= 1'b1;
        repeat (20) @(posedge clk);
        rd_chk(CDT_ADDR_STATUS, 32'h4);
        wr_reg(CDT_ADDR_OUT_SEL, {24'h0, CDT_OUT_TIMER});
        wait_out(1'b1);
        rd_chk(CDT_ADDR_STATUS, 32'h7);
        delay_run(1'b0, 0);
        repeat (4) begin
            on_d = $urandom_range(2, 5);
            off_d = $urandom_range(2, 5);
            wr_reg(CDT_ADDR_ON_DELAY, on_d);
            wr_reg(CDT_ADDR_OFF_DELAY, off_d);
            chatter(1'b0, on_d);
            delay_run(1'b1, on_d);
            chatter(1'b1, off_d);
            delay_run(1'b0, off_d);
        end
        // reset in mid-run: settings must come back at their zero defaults
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(CDT_ADDR_ON_DELAY, 32'h0);
        rd_chk(CDT_ADDR_OFF_DELAY, 32'h0);
        rd_chk(CDT_ADDR_STATUS, 32'h0);
        wr_reg(CDT_ADDR_IN_SEL, {24'h0, CDT_IN_TIMER});
        wr_reg(CDT_ADDR_OUT_SEL, {24'h0, CDT_OUT_TIMER});
        wr_reg(CDT_ADDR_ON_DELAY, on_d);
        delay_run(1'b1, on_d);
        wr_reg(CDT_ADDR_OUT_SEL, 32'h0);
        wait_out(1'b0);
        chk({31'h0, n <= 4}, 32'h1);
        stop_test();
    end
endmodule : tb_top
